// File: adc_repeat_sweep_control.sv
// Repeat sweep modes 0 and 1 of the converter: start, sequencing, results, DMA, interrupt
//
// How it works
// - Mode 0 converts the selected group in turn and repeats the sweep.
// - Software trigger: sweeping begins once the start bit is written 1.
// - Pin trigger: a falling edge after the start bit is set begins sweeping.
// - Timer trigger: a timer request after the start bit is set begins sweeping.
// - Sweeping never ends by itself; only clearing the start bit stops it.
// - With DMA operation off no interrupt request is ever raised.
// - With DMA operation on every conversion sets the done flag, which raises an interrupt request while the mask enables it.
// - Mode 0 group holds 2, 4, 6 or 8 channels from channel 0.
// - Without DMA each result lands in the result register of its channel.
// - With DMA every result lands in result register zero.
// - Mode 1 converts a prioritized channel before each ordinary one.
// - Mode 1 always covers all eight channels of the port set.
// - Mode 1 prioritizes 1, 2, 3 or 4 channels from channel 0.
// - Once sweeping, further trigger edges are ignored.
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "adc_sweep_defines.svh"

module adc_repeat_sweep_control #(
    parameter int RESULT_W = 10
) (
    // System
    input wire logic clk_sys,
    input wire logic reset,
    // Register port
    input wire logic [`ADC_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // Trigger sources
    input wire logic external_trigger_pin,
    input wire logic timer_trigger,
    // Converter core
    output adc_sweep_pkg::conv_req_t conv_req,
    input wire logic conv_done,
    input wire logic [RESULT_W-1:0] conv_data,
    // DMA and interrupt
    output logic dma_request,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    // Last channel of the mode 0 group: 2, 4, 6 or 8 channels
    function automatic logic [2:0] group_last(input logic hi, input logic lo);
        group_last = {hi, lo, 1'b1};
    endfunction

    // Number of prioritized channels in mode 1, less one
    function automatic logic [2:0] prio_last(input logic hi, input logic lo);
        prio_last = {1'b0, hi, lo};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // State

    adc_sweep_pkg::cfg_t cfg;
    adc_sweep_pkg::cfg_t next_cfg;
    adc_sweep_pkg::state_t state;
    adc_sweep_pkg::state_t next_state;
    adc_sweep_pkg::conv_req_t next_conv_req;
    logic [`ADC_IRQ_W-1:0] status;
    logic [`ADC_IRQ_W-1:0] next_status;
    logic [`ADC_IRQ_W-1:0] mask;
    logic [`ADC_IRQ_W-1:0] next_mask;
    logic phase;
    logic next_phase;
    logic [2:0] prio_ch;
    logic [2:0] next_prio_ch;
    logic [2:0] norm_ch;
    logic [2:0] next_norm_ch;
    logic [RESULT_W-1:0] results [`ADC_CHANNELS];
    logic [RESULT_W-1:0] next_results [`ADC_CHANNELS];
    logic [31:0] next_rdata;
    logic next_dma_request;
    logic next_irq;
    logic pin_fall;
    logic trig_event;
    logic done_ok;
    logic [2:0] g_last;
    logic [2:0] p_last;

    trigger_pin_filter u_pin_filter (
        .clk_sys(clk_sys),
        .reset(reset),
        .pin(external_trigger_pin),
        .fall(pin_fall)
    );

    assign trig_event = cfg.trig_src ? timer_trigger : pin_fall;
    assign g_last = group_last(cfg.scan_select_hi, cfg.scan_select_lo);
    assign p_last = prio_last(cfg.scan_select_hi, cfg.scan_select_lo);

    ////////////////////////////////////////////////////////////////////////////////
    // Next values

    always_comb begin
        next_cfg = cfg;
        next_mask = mask;
        next_status = status;
        next_state = state;
        next_phase = phase;
        next_prio_ch = prio_ch;
        next_norm_ch = norm_ch;
        next_conv_req = conv_req;
        next_conv_req.start = 1'b0;
        next_dma_request = 1'b0;
        next_results = results;
        next_rdata = 32'h0000_0000;
        done_ok = 1'b0;

        // Register writes
        if (reg_write) begin
            if (reg_addr == `ADC_CTRL0_OFS) begin
                next_cfg.start = reg_wdata[`ADC_START_BIT];
                next_cfg.trig_sel = reg_wdata[`ADC_TRIG_SEL_BIT];
                next_cfg.mode = reg_wdata[`ADC_MODE_BIT];
            end else if (reg_addr == `ADC_CTRL1_OFS) begin
                next_cfg.scan_select_lo = reg_wdata[`ADC_SCAN_LO_BIT];
                next_cfg.scan_select_hi = reg_wdata[`ADC_SCAN_HI_BIT];
            end else if (reg_addr == `ADC_CTRL2_OFS) begin
                next_cfg.pin_group_select_lo = reg_wdata[`ADC_GROUP_LO_BIT];
                next_cfg.pin_group_select_hi = reg_wdata[`ADC_GROUP_HI_BIT];
                next_cfg.trig_src = reg_wdata[`ADC_TRIG_SRC_BIT];
            end else if (reg_addr == `ADC_CTRL3_OFS) begin
                next_cfg.dma = reg_wdata[`ADC_DMA_BIT];
            end else if (reg_addr == `ADC_STATUS_OFS) begin
                next_status = status & ~reg_wdata[`ADC_IRQ_W-1:0];
            end else if (reg_addr == `ADC_MASK_OFS) begin
                next_mask = reg_wdata[`ADC_IRQ_W-1:0];
            end
        end

        // Sweep sequencer
        case (state)
            adc_sweep_pkg::ST_IDLE: begin
                next_phase = 1'b0;
                next_prio_ch = 3'h0;
                next_norm_ch = next_cfg.mode ? p_last + 3'h1 : 3'h0;
                if (next_cfg.start) begin
                    // Pin or timer events before the start bit never reach here
                    next_state = next_cfg.trig_sel ? adc_sweep_pkg::ST_ARMED
                                                   : adc_sweep_pkg::ST_ISSUE;
                end
            end
            adc_sweep_pkg::ST_ARMED: begin
                if (trig_event) begin
                    next_state = adc_sweep_pkg::ST_ISSUE;
                end
            end
            adc_sweep_pkg::ST_ISSUE: begin
                next_conv_req.start = 1'b1;
                next_conv_req.group = {cfg.pin_group_select_hi, cfg.pin_group_select_lo};
                if (cfg.mode && !phase) begin
                    next_conv_req.channel = prio_ch;
                end else begin
                    next_conv_req.channel = norm_ch;
                end
                next_state = adc_sweep_pkg::ST_WAIT;
            end
            adc_sweep_pkg::ST_WAIT: begin
                // Triggers are not looked at while sweeping
                if (conv_done) begin
                    done_ok = 1'b1;
                    if (cfg.dma) begin
                        next_results[0] = conv_data;
                        next_dma_request = 1'b1;
                    end else begin
                        next_results[conv_req.channel] = conv_data;
                    end
                    if (!cfg.mode) begin
                        next_norm_ch = (norm_ch >= g_last) ? 3'h0 : norm_ch + 3'h1;
                    end else if (!phase) begin
                        next_prio_ch = (prio_ch >= p_last) ? 3'h0 : prio_ch + 3'h1;
                        next_phase = 1'b1;
                    end else begin
                        next_norm_ch = (norm_ch == `ADC_LAST_CHANNEL) ? p_last + 3'h1
                                                                     : norm_ch + 3'h1;
                        next_phase = 1'b0;
                    end
                    next_state = adc_sweep_pkg::ST_ISSUE;
                end
            end
            default: begin
                next_state = adc_sweep_pkg::ST_IDLE;
            end
        endcase

        // Only clearing the start bit leaves the sweep
        if (!next_cfg.start) begin
            next_state = adc_sweep_pkg::ST_IDLE;
        end

        // Conversion flag set wins over a clear in the same cycle
        if (done_ok && cfg.dma) begin
            next_status[`ADC_DONE_BIT] = 1'b1;
        end
        next_irq = |(next_status & next_mask);

        // Register reads, answered one cycle later
        if (reg_read) begin
            if (reg_addr == `ADC_CTRL0_OFS) begin
                next_rdata[`ADC_START_BIT] = cfg.start;
                next_rdata[`ADC_TRIG_SEL_BIT] = cfg.trig_sel;
                next_rdata[`ADC_MODE_BIT] = cfg.mode;
            end else if (reg_addr == `ADC_CTRL1_OFS) begin
                next_rdata[`ADC_SCAN_LO_BIT] = cfg.scan_select_lo;
                next_rdata[`ADC_SCAN_HI_BIT] = cfg.scan_select_hi;
            end else if (reg_addr == `ADC_CTRL2_OFS) begin
                next_rdata[`ADC_GROUP_LO_BIT] = cfg.pin_group_select_lo;
                next_rdata[`ADC_GROUP_HI_BIT] = cfg.pin_group_select_hi;
                next_rdata[`ADC_TRIG_SRC_BIT] = cfg.trig_src;
            end else if (reg_addr == `ADC_CTRL3_OFS) begin
                next_rdata[`ADC_DMA_BIT] = cfg.dma;
            end else if (reg_addr == `ADC_STATUS_OFS) begin
                next_rdata[`ADC_IRQ_W-1:0] = status;
            end else if (reg_addr == `ADC_MASK_OFS) begin
                next_rdata[`ADC_IRQ_W-1:0] = mask;
            end else if (reg_addr[`ADC_RESULT_BASE_BIT] && reg_addr[1:0] == 2'h0) begin
                next_rdata[RESULT_W-1:0] = results[reg_addr[4:2]];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cfg <= '0;
            state <= adc_sweep_pkg::ST_IDLE;
            conv_req <= '0;
            status <= `ADC_STATUS_RESET;
            mask <= `ADC_MASK_RESET;
            phase <= 1'b0;
            prio_ch <= 3'h0;
            norm_ch <= 3'h0;
            reg_rdata <= 32'h0000_0000;
            dma_request <= 1'b0;
            irq <= 1'b0;
            for (int i = 0; i < `ADC_CHANNELS; i++) begin
                results[i] <= '0;
            end
        end else begin
            cfg <= next_cfg;
            state <= next_state;
            conv_req <= next_conv_req;
            status <= next_status;
            mask <= next_mask;
            phase <= next_phase;
            prio_ch <= next_prio_ch;
            norm_ch <= next_norm_ch;
            reg_rdata <= next_rdata;
            dma_request <= next_dma_request;
            irq <= next_irq;
            results <= next_results;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    logic ctrl0_write;
    assign ctrl0_write = reg_write && reg_addr == `ADC_CTRL0_OFS;

    sequence s_issue_then_start;
        state == adc_sweep_pkg::ST_ISSUE ##1 conv_req.start;
    endsequence

    AST_SW_START: assert property ($rose(cfg.start) && !cfg.trig_sel |-> s_issue_then_start)
        else $error("software start did not begin a conversion");
    AST_ARMED_HOLDS: assert property (state == adc_sweep_pkg::ST_ARMED && !trig_event
        && !ctrl0_write |=> state == adc_sweep_pkg::ST_ARMED && !conv_req.start)
        else $error("armed sweep began without a trigger");
    AST_TRIGGER_STARTS: assert property (state == adc_sweep_pkg::ST_ARMED && trig_event
        && !ctrl0_write |=> s_issue_then_start)
        else $error("trigger did not begin the sweep");
    AST_STOP: assert property (ctrl0_write && !reg_wdata[`ADC_START_BIT]
        |=> state == adc_sweep_pkg::ST_IDLE ##1 !conv_req.start)
        else $error("sweep kept running after the start bit was cleared");
    AST_NO_IRQ_NO_DMA: assert property ($rose(status[`ADC_DONE_BIT]) |-> $past(cfg.dma))
        else $error("interrupt flag set with DMA operation off");
    AST_DMA_PER_DONE: assert property (done_ok && cfg.dma
        |=> dma_request && status[`ADC_DONE_BIT] && results[0] == $past(conv_data))
        else $error("finished conversion gave no request or result");
    AST_PER_CHANNEL: assert property (done_ok && !cfg.dma
        |=> results[$past(conv_req.channel)] == $past(conv_data) && !dma_request)
        else $error("result not stored by channel");
    AST_MODE0_GROUP: assert property (conv_req.start && !cfg.mode |-> conv_req.channel <= g_last)
        else $error("mode 0 channel outside the group");
    AST_MODE1_ORDER: assert property (state == adc_sweep_pkg::ST_ISSUE && cfg.mode && !phase
        |=> conv_req.channel <= p_last)
        else $error("mode 1 prioritized slot took an ordinary channel");
    AST_MODE1_ORDINARY: assert property (state == adc_sweep_pkg::ST_ISSUE && cfg.mode && phase
        |=> conv_req.channel > p_last)
        else $error("mode 1 ordinary slot took a prioritized channel");
    AST_WRAP: assert property (done_ok && !ctrl0_write |=> s_issue_then_start)
        else $error("sweep paused after a conversion");
    AST_NO_RETRIGGER: assert property (state == adc_sweep_pkg::ST_WAIT && !conv_done
        && !ctrl0_write |=> state == adc_sweep_pkg::ST_WAIT)
        else $error("sweep disturbed while a conversion ran");

endmodule

// File: adc_sweep_defines.svh
// Register offsets, field positions, reset values of the repeat sweep control
`ifndef ADC_SWEEP_DEFINES_SVH
`define ADC_SWEEP_DEFINES_SVH

`define ADC_ADDR_W 6
`define ADC_CTRL0_OFS 6'h00
`define ADC_CTRL1_OFS 6'h04
`define ADC_CTRL2_OFS 6'h08
`define ADC_CTRL3_OFS 6'h0C
`define ADC_STATUS_OFS 6'h10
`define ADC_MASK_OFS 6'h14
`define ADC_RESULT_BASE_BIT 5

`define ADC_START_BIT 0
`define ADC_TRIG_SEL_BIT 1
`define ADC_MODE_BIT 2
`define ADC_SCAN_LO_BIT 0
`define ADC_SCAN_HI_BIT 1
`define ADC_GROUP_LO_BIT 0
`define ADC_GROUP_HI_BIT 1
`define ADC_TRIG_SRC_BIT 2
`define ADC_DMA_BIT 0
`define ADC_DONE_BIT 0

`define ADC_CHANNELS 8
`define ADC_LAST_CHANNEL 3'h7
`define ADC_IRQ_W 1
`define ADC_STATUS_RESET 1'h0
`define ADC_MASK_RESET 1'h0
`define ADC_PIN_IDLE 1'h1

`endif

// File: adc_sweep_pkg.sv
// Types shared by the repeat sweep control
package adc_sweep_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_ISSUE,
        ST_WAIT
    } state_t;

    typedef struct packed {
        logic mode;
        logic start;
        logic trig_sel;
        logic trig_src;
        logic scan_select_hi;
        logic scan_select_lo;
        logic pin_group_select_hi;
        logic pin_group_select_lo;
        logic dma;
    } cfg_t;

    typedef struct packed {
        logic start;
        logic [2:0] channel;
        logic [1:0] group;
    } conv_req_t;

endpackage

// File: conv_core_model.sv
// Behavioural converter core answering each conversion request
`timescale 1ns/1ps

module conv_core_model #(
    parameter int RESULT_W = 10
) (
    // System
    input wire logic clk_sys,
    // Request and pace
    input wire adc_sweep_pkg::conv_req_t conv_req,
    input wire logic slow,
    // Answer
    output logic conv_done,
    output logic [RESULT_W-1:0] conv_data
);
    int wait_left;
    logic [6:0] serial;

    initial begin
        conv_done = 1'b0;
        conv_data = '0;
        wait_left = 0;
        serial = 7'h00;
    end

    // One done per start; a new start restarts the count
    always @(posedge clk_sys) begin
        conv_done <= 1'b0;
        // Data line never keeps a stale result
        conv_data <= ~conv_data;
        if (conv_req.start) begin
            wait_left = slow ? 8 : 2;
        end else if (wait_left > 0) begin
            wait_left = wait_left - 1;
            if (wait_left == 0) begin
                conv_done <= 1'b1;
                conv_data <= RESULT_W'({conv_req.channel, serial});
                serial = serial + 7'h01;
            end
        end
    end
endmodule

// File: tb_top.sv
// Self-checking bench of the repeat sweep control
`timescale 1ns/1ps
`include "adc_sweep_defines.svh"

module tb_top;
    logic clk_sys, reset, reg_write, reg_read, pin, timer, slow, conv_done, dma_request, irq;
    logic [5:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd;
    logic [9:0] conv_data, last_any;
    logic [9:0] last [8];
    adc_sweep_pkg::conv_req_t conv_req;
    logic cur_mode, cur_dma, running;
    logic [1:0] cur_scan, cur_group;
    int failures, comparisons, idx, starts, dones, dmas, gap, s0;
    logic [4:0] rows [8] = '{5'h00, 5'h05, 5'h0A, 5'h0F, 5'h13, 5'h16, 5'h19, 5'h1C};

    adc_repeat_sweep_control adc_repeat_sweep_control_inst (
        .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .external_trigger_pin(pin), .timer_trigger(timer), .conv_req(conv_req),
        .conv_done(conv_done), .conv_data(conv_data), .dma_request(dma_request), .irq(irq));
    conv_core_model conv_core_model_inst (.clk_sys(clk_sys), .conv_req(conv_req),
        .slow(slow), .conv_done(conv_done), .conv_data(conv_data));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic [5:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
        // Lets an edge pass so a following write never re-drives the strobe in this step
        @(posedge clk_sys);
    endtask

    task automatic reg_rd(input logic [5:0] a);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1 rd = reg_rdata;
        @(posedge clk_sys);
    endtask

    task automatic setup(input logic m, s1, s0b, g1, g0, src, dma);
        cur_mode = m;
        cur_scan = {s1, s0b};
        cur_group = {g1, g0};
        cur_dma = dma;
        reg_wr(`ADC_CTRL1_OFS, {30'h0, s1, s0b});
        reg_wr(`ADC_CTRL2_OFS, {29'h0, src, g1, g0});
        reg_wr(`ADC_CTRL3_OFS, {31'h0, dma});
        idx = 0;
        running = 1'b1;
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // Waits for n requests, stops, then checks nothing more is issued
    task automatic sweep_until(input int n);
        int w;
        w = 0;
        while (idx < n && w < 3000) begin
            @(posedge clk_sys);
            w++;
        end
        check(32'(idx >= n), 32'h1);
        running = 1'b0;
        reg_wr(`ADC_CTRL0_OFS, 32'h0);
        s0 = starts;
        wait_clk(30);
        check(32'(starts), 32'(s0));
    endtask

    function automatic logic [2:0] exp_ch(input logic m, input logic [1:0] s, input int k);
        int p;
        p = s + 1;
        if (!m) return 3'(k % (2 * p));
        if (k % 2 == 0) return 3'((k / 2) % p);
        return 3'(p + (k / 2) % (8 - p));
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Monitor of requests, completions and events
    always @(posedge clk_sys) begin
        gap++;
        if (conv_req.start) begin
            starts++;
            if (running) begin
                check(32'(conv_req.channel), 32'(exp_ch(cur_mode, cur_scan, idx)));
                check(32'(conv_req.group), 32'(cur_group));
                if (idx > 0) check(32'(gap), 32'h2);
                idx++;
            end
        end
        if (conv_done && running) begin
            last[conv_req.channel] = conv_data;
            last_any = conv_data;
            dones++;
            gap = 0;
        end
        if (dma_request) dmas++;
        if (!cur_dma && (irq || dma_request)) check(32'(irq | dma_request), 32'h0);
    end

    initial begin
        #100000;
        failures++;
        final_report();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {reg_addr, reg_wdata, reg_write, reg_read, timer, slow, running, cur_dma} = '0;
        {failures, comparisons, idx, starts, dones, dmas, gap} = '0;
        for (int j = 0; j < 8; j++) last[j] = 10'h000;
        pin = 1'b1;
        reset = 1'b1;
        wait_clk(4);
        reset <= 1'b0;
        @(posedge clk_sys);
        foreach (rows[i]) begin
            reg_rd(6'(`ADC_CTRL0_OFS + 4 * i));
            check(rd, 32'h0);
        end
        $display("test reset_values done");
        foreach (rows[r]) begin
            slow <= rows[r][0];
            setup(rows[r][4], rows[r][3], rows[r][2], rows[r][1], rows[r][0], 1'b0, 1'b0);
            reg_wr(`ADC_CTRL0_OFS, {29'h0, rows[r][4], 2'b01});
            sweep_until(18);
            for (int j = 0; j < 8; j++) begin
                reg_rd(6'(32 + 4 * j));
                check(rd, {22'h0, last[j]});
            end
            $display("test row %0d done", r);
        end
        slow <= 1'b0;
        setup(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
        reg_wr(`ADC_MASK_OFS, 32'h1);
        dones = 0;
        dmas = 0;
        reg_wr(`ADC_CTRL0_OFS, 32'h1);
        sweep_until(6);
        check(32'(dmas), 32'(dones));
        check(32'(irq), 32'h1);
        reg_rd(`ADC_STATUS_OFS);
        check(rd, 32'h1);
        reg_wr(`ADC_MASK_OFS, 32'h0);
        @(posedge clk_sys);
        check(32'(irq), 32'h0);
        reg_rd(6'h20);
        check(rd, {22'h0, last_any});
        reg_wr(`ADC_STATUS_OFS, 32'h1);
        reg_rd(`ADC_STATUS_OFS);
        check(rd, 32'h0);
        reg_rd(6'h18);
        check(rd, 32'h0);
        $display("test dma done");
        setup(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        reg_wr(`ADC_CTRL0_OFS, 32'h6);
        pin <= 1'b0;
        wait_clk(10);
        pin <= 1'b1;
        wait_clk(10);
        reg_wr(`ADC_CTRL0_OFS, 32'h7);
        wait_clk(20);
        check(32'(idx), 32'h0);
        pin <= 1'b0;
        wait_clk(40);
        pin <= 1'b1;
        wait_clk(20);
        pin <= 1'b0;
        wait_clk(30);
        pin <= 1'b1;
        sweep_until(18);
        $display("test pin_trigger done");
        setup(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
        reg_wr(`ADC_CTRL0_OFS, 32'h2);
        timer <= 1'b1;
        @(posedge clk_sys);
        timer <= 1'b0;
        wait_clk(20);
        reg_wr(`ADC_CTRL0_OFS, 32'h3);
        check(32'(idx), 32'h0);
        timer <= 1'b1;
        @(posedge clk_sys);
        timer <= 1'b0;
        wait_clk(30);
        timer <= 1'b1;
        @(posedge clk_sys);
        timer <= 1'b0;
        sweep_until(20);
        $display("test timer_trigger done");
        final_report();
    end
endmodule

// File: trigger_pin_filter.sv
// Synchroniser and falling-edge detector for the external trigger pin
`timescale 1ns/1ps
`include "adc_sweep_defines.svh"

module trigger_pin_filter (
    // System
    input wire logic clk_sys,
    input wire logic reset,
    // Pin and event
    input wire logic pin,
    output logic fall
);

    logic sync1;
    logic sync2;
    logic sync3;
    logic level;
    logic next_level;
    logic next_fall;

    always_comb begin
        next_level = level;
        next_fall = 1'b0;
        if (sync2 == sync3 && sync3 != level) begin
            next_level = sync3;
            next_fall = level && !sync3;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sync1 <= `ADC_PIN_IDLE;
            sync2 <= `ADC_PIN_IDLE;
            sync3 <= `ADC_PIN_IDLE;
            level <= `ADC_PIN_IDLE;
            fall <= 1'b0;
        end else begin
            sync1 <= pin;
            sync2 <= sync1;
            sync3 <= sync2;
            level <= next_level;
            fall <= next_fall;
        end
    end

    AST_FALL_NEEDS_AGREEMENT: assert property (@(posedge clk_sys) disable iff (reset)
        fall |-> $past(level) && !level && $past(sync2) == $past(sync3))
        else $error("trigger edge taken before the synchroniser settled");

endmodule
